// File: pkg/smseq_cfg.svh
// Offsets, field positions, reset values and timing counts of the muting sequencer
`ifndef SMSEQ_CFG_SVH
`define SMSEQ_CFG_SVH

`define SMSEQ_CLK_MHZ 100
`define SMSEQ_CONC_MS 3000
`define SMSEQ_SEP_MS 50
`define SMSEQ_CONC_CYC (`SMSEQ_CONC_MS * 1000 * `SMSEQ_CLK_MHZ)
`define SMSEQ_SEP_CYC (`SMSEQ_SEP_MS * 1000 * `SMSEQ_CLK_MHZ)

`define SMSEQ_ADDR_CTRL 8'h00
`define SMSEQ_ADDR_STATUS 8'h04
`define SMSEQ_ADDR_IRQ_STAT 8'h08
`define SMSEQ_ADDR_IRQ_MASK 8'h0c

`define SMSEQ_STATUS_MUTE_BIT 3
`define SMSEQ_STATUS_LOCK_BIT 4
`define SMSEQ_STATUS_ACT_LSB 8

`define SMSEQ_IRQ_MUTE_ON 0
`define SMSEQ_IRQ_MUTE_OFF 1
`define SMSEQ_IRQ_SEQ_FAULT 2
`define SMSEQ_IRQ_LOCKOUT 3

`define SMSEQ_CTRL_RST 2'h0
`define SMSEQ_MASK_RST 4'h0
`define SMSEQ_RESP_OKAY 2'h0
`define SMSEQ_RESP_SLVERR 2'h2

`endif

// File: pkg/smseq_pkg.sv
// Types of the muting sequencer
`default_nettype none
package smseq_pkg;

    typedef enum logic [2:0] {
        SMSEQ_IDLE = 3'h0,
        SMSEQ_ARM = 3'h1,
        SMSEQ_MUTE = 3'h2,
        SMSEQ_BLOCK = 3'h3,
        SMSEQ_LOCK = 3'h4
    } smseq_state_e;

    typedef enum logic [1:0] {
        SMSEQ_M2 = 2'h0,
        SMSEQ_M3 = 2'h1,
        SMSEQ_M4 = 2'h2
    } smseq_mode_e;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } smseq_axi_s;

    typedef struct packed {
        smseq_state_e state;
        smseq_mode_e mode;
        logic dir;
        logic [2:0] nxt;
        logic [3:0] seen;
        logic [3:0] act;
        logic [3:0][31:0] age;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [1:0] sso;
        logic mute;
        logic lock;
        logic irq;
        smseq_axi_s axi;
    } smseq_regs_s;

endpackage
`default_nettype wire

// File: src/smseq_top.sv
// Muting sequencer for one safety channel with an AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "smseq_cfg.svh"

module smseq_top #(
    parameter int unsigned CONC_CYC = `SMSEQ_CONC_CYC,
    parameter int unsigned SEP_CYC = `SMSEQ_SEP_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic MUTE_EN,
    input wire logic [3:0] SENS,
    input wire logic [1:0] SAFE_IN,
    output logic [1:0] SAFETY_SWITCHING_OUTPUT,
    output logic MUTE_STAT,
    output logic LOCKOUT,
    output logic IRQ,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (CONC_CYC < 1 || SEP_CYC < 1 || SEP_CYC >= CONC_CYC) begin : g_bad_par
            $error("smseq_top: window counts must be nonzero and separation below concurrence");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Sensor at position k of the travel order
    function automatic logic [1:0] seq_sensor(input logic dir, input logic [2:0] k);
        logic [1:0] kk;
        kk = k[1:0];
        return dir ? ~kk : kk;
    endfunction

    // Both sensors of a pair started within the concurrence window
    function automatic logic concur_ok(input logic [31:0] age_x, input logic [31:0] age_y);
        return (age_x <= CONC_CYC) && (age_y <= CONC_CYC);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    smseq_pkg::smseq_regs_s q;
    smseq_pkg::smseq_regs_s d;

    always_comb begin
        logic [3:0] act;
        logic [3:0] rise;
        logic [3:0] clr;
        logic [3:0] ev;
        logic unused;
        logic flt;
        logic [1:0] expd;
        logic [1:0] prev;
        smseq_pkg::smseq_state_e nst;
        act = '0;
        rise = '0;
        clr = '0;
        ev = '0;
        unused = 1'b0;
        flt = 1'b0;
        expd = '0;
        prev = '0;
        nst = q.state;
        d = q;

        // Sensor polarity: A and C high, B and D low mean ok to mute
        act = {~SENS[3], SENS[2], ~SENS[1], SENS[0]};
        rise = act & ~q.act;
        d.act = act;
        for (int i = 0; i < 4; i++) begin
            if (!act[i]) begin
                d.age[i] = '0;
            end else if (q.age[i] != 32'hffffffff) begin
                d.age[i] = q.age[i] + 32'h1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Register bus

        if (S_AXI_AWVALID && q.axi.awready) begin
            d.axi.aw_have = 1'b1;
            d.axi.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && q.axi.wready) begin
            d.axi.w_have = 1'b1;
            d.axi.wdata = S_AXI_WDATA;
            d.axi.wstrb = S_AXI_WSTRB;
        end
        if (S_AXI_BREADY && q.axi.bvalid) begin
            d.axi.bvalid = 1'b0;
        end
        if (q.axi.aw_have && q.axi.w_have && !q.axi.bvalid) begin
            d.axi.aw_have = 1'b0;
            d.axi.w_have = 1'b0;
            d.axi.bvalid = 1'b1;
            d.axi.bresp = `SMSEQ_RESP_OKAY;
            unique case ({q.axi.awaddr[7:2], 2'b00})
                `SMSEQ_ADDR_CTRL: begin
                    // Reserved mode code is ignored
                    if (q.axi.wstrb[0] && q.axi.wdata[1:0] != 2'h3) begin
                        d.mode = smseq_pkg::smseq_mode_e'(q.axi.wdata[1:0]);
                    end
                end
                `SMSEQ_ADDR_STATUS: begin
                end
                `SMSEQ_ADDR_IRQ_STAT: begin
                    if (q.axi.wstrb[0]) begin
                        clr = q.axi.wdata[3:0];
                    end
                end
                `SMSEQ_ADDR_IRQ_MASK: begin
                    if (q.axi.wstrb[0]) begin
                        d.irq_mask = q.axi.wdata[3:0];
                    end
                end
                default: begin
                    d.axi.bresp = `SMSEQ_RESP_SLVERR;
                end
            endcase
        end
        d.axi.awready = !d.axi.aw_have && !d.axi.bvalid;
        d.axi.wready = !d.axi.w_have && !d.axi.bvalid;

        if (S_AXI_RREADY && q.axi.rvalid) begin
            d.axi.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && q.axi.arready) begin
            d.axi.rvalid = 1'b1;
            d.axi.rresp = `SMSEQ_RESP_OKAY;
            d.axi.rdata = '0;
            unique case ({S_AXI_ARADDR[7:2], 2'b00})
                `SMSEQ_ADDR_CTRL: d.axi.rdata[1:0] = q.mode;
                `SMSEQ_ADDR_STATUS: begin
                    d.axi.rdata[2:0] = q.state;
                    d.axi.rdata[`SMSEQ_STATUS_MUTE_BIT] = q.mute;
                    d.axi.rdata[`SMSEQ_STATUS_LOCK_BIT] = q.lock;
                    d.axi.rdata[`SMSEQ_STATUS_ACT_LSB +: 4] = q.act;
                end
                `SMSEQ_ADDR_IRQ_STAT: d.axi.rdata[3:0] = q.irq_stat;
                `SMSEQ_ADDR_IRQ_MASK: d.axi.rdata[3:0] = q.irq_mask;
                default: d.axi.rresp = `SMSEQ_RESP_SLVERR;
            endcase
        end
        d.axi.arready = !d.axi.rvalid;

        ////////////////////////////////////////////////////////////////////////
        // Sequencer

        unique case (q.mode)
            smseq_pkg::SMSEQ_M2: unused = act[3] | act[2];
            smseq_pkg::SMSEQ_M3: unused = act[3];
            smseq_pkg::SMSEQ_M4: unused = 1'b0;
        endcase

        if (!MUTE_EN) begin
            nst = smseq_pkg::SMSEQ_IDLE;
        end else if (unused) begin
            nst = smseq_pkg::SMSEQ_LOCK;
        end else begin
            unique case (q.state)
                smseq_pkg::SMSEQ_IDLE, smseq_pkg::SMSEQ_ARM, smseq_pkg::SMSEQ_MUTE: begin
                    if (act == 4'h0 && q.state != smseq_pkg::SMSEQ_MUTE) begin
                        nst = smseq_pkg::SMSEQ_IDLE;
                    end else if (q.state != smseq_pkg::SMSEQ_MUTE) begin
                        nst = smseq_pkg::SMSEQ_ARM;
                    end
                    unique case (q.mode)
                        smseq_pkg::SMSEQ_M2: begin
                            if (q.state == smseq_pkg::SMSEQ_MUTE) begin
                                if (act[1:0] != 2'b11) begin
                                    nst = smseq_pkg::SMSEQ_BLOCK;
                                end
                            end else if (act[1:0] == 2'b11) begin
                                if (concur_ok(q.age[0], q.age[1])) begin
                                    nst = smseq_pkg::SMSEQ_MUTE;
                                end else begin
                                    flt = 1'b1;
                                end
                            end else if ((act[0] && q.age[0] > CONC_CYC) || (act[1] && q.age[1] > CONC_CYC)) begin
                                flt = 1'b1;
                            end
                        end
                        smseq_pkg::SMSEQ_M3: begin
                            if (q.state == smseq_pkg::SMSEQ_MUTE) begin
                                if (act[1:0] != 2'b11) begin
                                    nst = smseq_pkg::SMSEQ_BLOCK;
                                    flt = act[2];
                                end
                            end else if ((act[0] || act[1]) && !act[2]) begin
                                flt = 1'b1;
                            end else if ((rise[0] || rise[1]) && q.age[2] < SEP_CYC) begin
                                flt = 1'b1;
                            end else if (act[1:0] == 2'b11) begin
                                if (concur_ok(q.age[0], q.age[1])) begin
                                    nst = smseq_pkg::SMSEQ_MUTE;
                                end else begin
                                    flt = 1'b1;
                                end
                            end else if ((act[0] && q.age[0] > CONC_CYC) || (act[1] && q.age[1] > CONC_CYC)) begin
                                flt = 1'b1;
                            end
                        end
                        smseq_pkg::SMSEQ_M4: begin
                            expd = seq_sensor(q.dir, q.nxt);
                            prev = seq_sensor(q.dir, q.nxt - 3'h1);
                            if (q.nxt == 3'h0) begin
                                // Travel may start at either end
                                if (rise == 4'b0001) begin
                                    d.dir = 1'b0;
                                    d.nxt = 3'h1;
                                    d.seen = rise;
                                end else if (rise == 4'b1000) begin
                                    d.dir = 1'b1;
                                    d.nxt = 3'h1;
                                    d.seen = rise;
                                end else if (rise != 4'h0) begin
                                    flt = 1'b1;
                                end
                            end else begin
                                if (rise != 4'h0) begin
                                    if (q.nxt != 3'h4 && rise == (4'b0001 << expd) && q.age[prev] >= SEP_CYC) begin
                                        d.nxt = q.nxt + 3'h1;
                                        d.seen = q.seen | rise;
                                    end else begin
                                        flt = 1'b1;
                                    end
                                end
                                if (q.nxt != 3'h4 && (q.seen & ~act) != 4'h0) begin
                                    flt = 1'b1;
                                end
                                if (q.nxt[0] && q.age[prev] > CONC_CYC) begin
                                    flt = 1'b1;
                                end
                                if (q.nxt == 3'h4
                                        && !(act[seq_sensor(q.dir, 3'h2)] && act[seq_sensor(q.dir, 3'h3)])) begin
                                    nst = smseq_pkg::SMSEQ_BLOCK;
                                end
                            end
                            if (q.state != smseq_pkg::SMSEQ_MUTE && d.nxt >= 3'h2) begin
                                nst = smseq_pkg::SMSEQ_MUTE;
                            end
                        end
                    endcase
                    if (flt) begin
                        nst = smseq_pkg::SMSEQ_BLOCK;
                    end
                end
                smseq_pkg::SMSEQ_BLOCK: begin
                    if (act == 4'h0) begin
                        nst = smseq_pkg::SMSEQ_IDLE;
                    end
                end
                smseq_pkg::SMSEQ_LOCK: begin
                end
                default: nst = smseq_pkg::SMSEQ_LOCK;
            endcase
        end

        if (nst == smseq_pkg::SMSEQ_IDLE || nst == smseq_pkg::SMSEQ_BLOCK || nst == smseq_pkg::SMSEQ_LOCK) begin
            d.nxt = 3'h0;
            d.seen = 4'h0;
        end
        d.state = nst;

        ////////////////////////////////////////////////////////////////////////
        // Outputs and events

        d.mute = nst == smseq_pkg::SMSEQ_MUTE;
        d.lock = nst == smseq_pkg::SMSEQ_LOCK;
        if (nst == smseq_pkg::SMSEQ_MUTE) begin
            d.sso = 2'h3;
        end else if (nst != smseq_pkg::SMSEQ_LOCK && SAFE_IN == 2'h3) begin
            d.sso = 2'h3;
        end else begin
            d.sso = 2'h0;
        end

        ev[`SMSEQ_IRQ_MUTE_ON] = d.mute && !q.mute;
        ev[`SMSEQ_IRQ_MUTE_OFF] = !d.mute && q.mute;
        ev[`SMSEQ_IRQ_SEQ_FAULT] = flt && nst == smseq_pkg::SMSEQ_BLOCK;
        ev[`SMSEQ_IRQ_LOCKOUT] = d.lock && !q.lock;
        // A new event wins over a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.irq = (d.irq_stat & d.irq_mask) != 4'h0;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ports

    assign SAFETY_SWITCHING_OUTPUT = q.sso;
    assign MUTE_STAT = q.mute;
    assign LOCKOUT = q.lock;
    assign IRQ = q.irq;
    assign S_AXI_AWREADY = q.axi.awready;
    assign S_AXI_WREADY = q.axi.wready;
    assign S_AXI_BRESP = q.axi.bresp;
    assign S_AXI_BVALID = q.axi.bvalid;
    assign S_AXI_ARREADY = q.axi.arready;
    assign S_AXI_RDATA = q.axi.rdata;
    assign S_AXI_RRESP = q.axi.rresp;
    assign S_AXI_RVALID = q.axi.rvalid;

endmodule
`default_nettype wire

// File: verification/smseq_field.sv
// Field sensors and mute permit switch in front of the sequencer
`timescale 1ns/100ps
`default_nettype none

module smseq_field (
    input wire logic en_req,
    input wire logic [3:0] act_req,
    output logic mute_en,
    output logic [3:0] sens
);
    // Logical activity to raw contact levels
    assign mute_en = en_req;
    assign sens[0] = act_req[0];
    assign sens[1] = ~act_req[1];
    assign sens[2] = act_req[2];
    assign sens[3] = ~act_req[3];
endmodule

`default_nettype wire

// File: verification/smseq_chk.sv
// Port checker of the muting sequencer
`timescale 1ns/100ps
`default_nettype none

module smseq_chk (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic MUTE_EN,
    input wire logic [3:0] SENS,
    input wire logic [1:0] SAFETY_SWITCHING_OUTPUT,
    input wire logic MUTE_STAT,
    input wire logic LOCKOUT,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire logic [3:0] act;
    assign act = {~SENS[3], SENS[2], ~SENS[1], SENS[0]};
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_b_wait;
        S_AXI_BVALID && !S_AXI_BREADY;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_PERMIT: assert property (!MUTE_EN |=> !MUTE_STAT)
        else $error("muting without permit");
    AST_LOCK_CLR: assert property (!MUTE_EN |=> !LOCKOUT)
        else $error("lockout kept without permit");
    AST_MUTE_SSO: assert property (MUTE_STAT |-> SAFETY_SWITCHING_OUTPUT == 2'h3)
        else $error("outputs off while muting");
    AST_LOCK_OFF: assert property (LOCKOUT |-> !MUTE_STAT && SAFETY_SWITCHING_OUTPUT == 2'h0)
        else $error("lockout with outputs or muting on");
    AST_MUTE_PAIR: assert property ($rose(MUTE_STAT) |-> $past(act[1:0]) == 2'h3 || $past(act[3:2]) == 2'h3)
        else $error("muting began without an active pair");
    AST_MUTE_IDLE: assert property (MUTE_STAT && act == 4'h0 |-> ##[1:2] !MUTE_STAT)
        else $error("muting kept with no sensor active");
    AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_b_wait |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    AST_RD_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read data late");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
endmodule

bind smseq_top smseq_chk i_chk (.CLK, .NRST, .MUTE_EN, .SENS, .SAFETY_SWITCHING_OUTPUT, .MUTE_STAT, .LOCKOUT,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY);

`default_nettype wire

// File: verification/smseq_top_tb.sv
// Self-checking bench of the muting sequencer
`timescale 1ns/100ps
`default_nettype none
`include "smseq_cfg.svh"

module smseq_top_tb;
    logic clk, nrst, en, mute_en, mute, lock, irq;
    logic [3:0] act, sens;
    logic [1:0] safe_in, sso, bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    int err_count, checks_done;

    smseq_field i_field (.en_req(en), .act_req(act), .mute_en(mute_en), .sens(sens));
    smseq_top #(.CONC_CYC(40), .SEP_CYC(8)) i_dut (.CLK(clk), .NRST(nrst), .MUTE_EN(mute_en), .SENS(sens),
        .SAFE_IN(safe_in), .SAFETY_SWITCHING_OUTPUT(sso), .MUTE_STAT(mute), .LOCKOUT(lock), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));

    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        chk(bresp, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, r);
    endtask

    // Set sensor activity, then let n cycles pass
    task automatic go(input logic [3:0] a, input int n);
        @(posedge clk);
        act <= a;
        repeat (n) @(posedge clk);
    endtask

    task automatic st(input logic m, input logic l, input logic [1:0] s);
        chk(mute, m);
        chk(lock, l);
        chk(sso, s);
    endtask

    // Lockout while permit high, then permit low, then permit back
    task automatic unlock(input logic [3:0] a);
        go(a, 3);
        st(1'b0, 1'b1, 2'h0);
        en <= 1'b0;
        go(4'h0, 3);
        st(1'b0, 1'b0, 2'h0);
        en <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        en = 1'b0;
        act = 4'h0;
        safe_in = 2'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`SMSEQ_ADDR_CTRL, 32'h0, `SMSEQ_RESP_OKAY);
        rd(`SMSEQ_ADDR_IRQ_MASK, 32'h0, `SMSEQ_RESP_OKAY);
        rd(8'h10, 32'h0, `SMSEQ_RESP_SLVERR);
        wr(8'h10, 32'h1, `SMSEQ_RESP_SLVERR);
        wr(`SMSEQ_ADDR_IRQ_MASK, 32'h1, `SMSEQ_RESP_OKAY);
        go(4'h3, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h7, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 3);
        en <= 1'b1;
        go(4'h1, 10);
        st(1'b0, 1'b0, 2'h0);
        go(4'h3, 3);
        st(1'b1, 1'b0, 2'h3);
        chk(irq, 1'b1);
        rd(`SMSEQ_ADDR_STATUS, 32'h30a, `SMSEQ_RESP_OKAY);
        go(4'h2, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 3);
        go(4'h2, 5);
        go(4'h3, 3);
        st(1'b1, 1'b0, 2'h3);
        go(4'h0, 3);
        go(4'h1, 50);
        go(4'h3, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h1, 3);
        go(4'h3, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        unlock(4'h4);
        unlock(4'h8);
        rd(`SMSEQ_ADDR_IRQ_STAT, 32'hf, `SMSEQ_RESP_OKAY);
        wr(`SMSEQ_ADDR_IRQ_STAT, 32'hf, `SMSEQ_RESP_OKAY);
        rd(`SMSEQ_ADDR_IRQ_STAT, 32'h0, `SMSEQ_RESP_OKAY);
        chk(irq, 1'b0);
        wr(`SMSEQ_ADDR_IRQ_MASK, 32'h0, `SMSEQ_RESP_OKAY);
        wr(`SMSEQ_ADDR_CTRL, 32'h1, `SMSEQ_RESP_OKAY);
        unlock(4'h8);
        go(4'h4, 10);
        go(4'h5, 3);
        go(4'h7, 3);
        st(1'b1, 1'b0, 2'h3);
        chk(irq, 1'b0);
        go(4'h3, 5);
        st(1'b1, 1'b0, 2'h3);
        go(4'h0, 5);
        go(4'h1, 5);
        go(4'h3, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h4, 2);
        go(4'h5, 10);
        go(4'h7, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h4, 10);
        go(4'h5, 50);
        go(4'h7, 3);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        wr(`SMSEQ_ADDR_CTRL, 32'h2, `SMSEQ_RESP_OKAY);
        go(4'h1, 10);
        st(1'b0, 1'b0, 2'h0);
        go(4'h3, 10);
        st(1'b1, 1'b0, 2'h3);
        go(4'h7, 10);
        go(4'hf, 10);
        go(4'hc, 10);
        st(1'b1, 1'b0, 2'h3);
        go(4'h8, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h1, 10);
        go(4'h3, 10);
        go(4'h7, 10);
        go(4'h6, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h8, 10);
        go(4'hc, 10);
        st(1'b1, 1'b0, 2'h3);
        go(4'he, 10);
        go(4'hf, 10);
        go(4'h3, 10);
        st(1'b1, 1'b0, 2'h3);
        go(4'h0, 5);
        go(4'h2, 10);
        go(4'h3, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h1, 3);
        go(4'h3, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        go(4'h1, 50);
        go(4'h3, 5);
        st(1'b0, 1'b0, 2'h0);
        go(4'h0, 5);
        safe_in <= 2'h3;
        go(4'h0, 3);
        st(1'b0, 1'b0, 2'h3);
        stop_test();
    end
endmodule

`default_nettype wire
